//--- design/dgp_pkg.sv
package dgp_pkg;

    // ------------------------------------------------------------
    // register map (offsets chosen for this block)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_SIX_LATCH     = 4'h0;
    localparam logic [3:0] ADDR_SIX_DIR       = 4'h1;
    localparam logic [3:0] ADDR_SIX_PULLUP    = 4'h2;
    localparam logic [3:0] ADDR_F_LATCH       = 4'h3;
    localparam logic [3:0] ADDR_F_DIR         = 4'h4;
    localparam logic [3:0] ADDR_STANDBY_CTRL  = 4'h5;
    localparam logic [3:0] ADDR_WAKE_SELECT   = 4'h6;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         STBY_ISOLATE_BIT   = 0;
    localparam int         WAKE_IRQ_A_BIT     = 0;
    localparam int         WAKE_IRQ_B_BIT     = 1;
    localparam int         WAKE_CLK_IN_BIT    = 2;
    localparam int         WAKE_TRIG_BIT      = 3;
    localparam int         SIX_IRQ_A_PIN      = 0;
    localparam int         SIX_IRQ_B_PIN      = 1;
    localparam int         SIX_CLK_IN_PIN     = 4;
    localparam int         SIX_TRIG_PIN       = 7;
    localparam int         F_RESET_PIN        = 2;
    localparam logic [7:0] SIX_PULLUP_MASK    = 8'hFC;
    localparam logic [7:0] RST_SIX_LATCH      = 8'h00;
    localparam logic [7:0] RST_SIX_DIR        = 8'h00;
    localparam logic [7:0] RST_SIX_PULLUP     = 8'h00;
    localparam logic [2:0] RST_F_LATCH        = 3'h0;
    localparam logic [2:0] RST_F_DIR          = 3'h0;
    localparam logic [7:0] RST_BYTE           = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       rmw;
    } dgp_bus_t;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
        logic [7:0] pu;
    } dgp_pins_t;

    typedef enum logic [0:0] {
        PM_RUN     = 1'b0,
        PM_ISOLATE = 1'b1
    } dgp_pmode_t;

    typedef struct packed {
        logic [7:0] sixLatch;
        logic [7:0] sixDir;
        logic [7:0] sixPullup;
        logic [2:0] fLatch;
        logic [2:0] fDir;
        logic       isolate;
        logic [3:0] wakeSel;
        logic [7:0] sixSync1;
        logic [7:0] sixSync2;
        logic [2:0] fSync1;
        logic [2:0] fSync2;
        dgp_pmode_t pmode;
        logic [7:0] rdata;
    } dgp_state_t;

endpackage

//--- design/dgp_port.sv
`timescale 1ns/1ps
// Behaviour
// - direction bit 1 output, 0 input
// - output pin drives its latch bit
// - writes always update latch; pin only if output
// - normal read of output bit returns latch
// - normal read of input bit returns pin
// - read-modify-write read always returns latch
// - peripheral output enable overrides port latch
// - peripheral driven pin reads back pin level
// - reset clears all direction bits
// - isolate bit plus stop/watch: Hi-Z, inputs low
// - enabled wake-up pins keep input path open
// - isolate bit clear: standby changes nothing
// - pull-up on when enabled, off when driven low
// - open-drain pin writing 1 stays Hi-Z
// - six port bits map pins; no pull-up pins 0,1
// - port F three bits, data and direction only
// - variant: port F pin 2 is reset only
// - port F follows same port behaviour
module dgp_port #(
    parameter logic [7:0] SIX_OPEN_DRAIN = 8'h00,
    parameter logic [2:0] F_OPEN_DRAIN   = 3'h0,
    parameter bit         F_PIN2_IS_RESET = 1'b0
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              clkEn,
    input  wire dgp_pkg::dgp_bus_t busReq,
    output logic [7:0]             busRdata,
    input  wire logic              stopOrWatch,
    input  wire dgp_pkg::dgp_pins_t sixPeriph,
    input  wire logic [7:0]        sixPinIn,
    output dgp_pkg::dgp_pins_t     sixPinOut,
    output logic [7:0]             sixCoreIn,
    input  wire logic [2:0]        fPinIn,
    output logic [2:0]             fPinOut,
    output logic [2:0]             fPinOe,
    output logic [2:0]             fCoreIn
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    initial begin
        if (F_PIN2_IS_RESET && F_OPEN_DRAIN[2]) begin
            $error("port F pin 2 cannot be both reset-only and open drain");
        end
    end

    dgp_pkg::dgp_state_t st_reg;
    dgp_pkg::dgp_state_t st_next;
    logic                isoActive;
    logic [7:0]          sixKeep;
    logic [7:0]          sixDrive;
    logic [7:0]          sixVal;
    logic [7:0]          sixOe;
    logic [2:0]          fUsable;

    // merge latch, direction and peripheral enables per pin
    function automatic logic [7:0] mux_read(input logic [7:0] latch,
                                            input logic [7:0] dir,
                                            input logic [7:0] periph,
                                            input logic [7:0] pin,
                                            input logic       rmw);
        logic [7:0] gpioOut;
        gpioOut = dir & ~periph;
        if (rmw) begin
            mux_read = latch;
        end else begin
            mux_read = (latch & gpioOut) | (pin & ~gpioOut);
        end
    endfunction

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // isolation only in the isolate mode state; bit clear leaves pins alone
    assign isoActive = (st_reg.pmode == dgp_pkg::PM_ISOLATE);
    assign fUsable   = F_PIN2_IS_RESET ? 3'h3 : 3'h7;

    // wake-up pins enabled in wakeSel keep their input path under isolation
    always_comb begin
        sixKeep = 8'h00;
        sixKeep[dgp_pkg::SIX_IRQ_A_PIN]  = st_reg.wakeSel[dgp_pkg::WAKE_IRQ_A_BIT];
        sixKeep[dgp_pkg::SIX_IRQ_B_PIN]  = st_reg.wakeSel[dgp_pkg::WAKE_IRQ_B_BIT];
        sixKeep[dgp_pkg::SIX_CLK_IN_PIN] = st_reg.wakeSel[dgp_pkg::WAKE_CLK_IN_BIT];
        sixKeep[dgp_pkg::SIX_TRIG_PIN]   = st_reg.wakeSel[dgp_pkg::WAKE_TRIG_BIT];
    end

    // peripheral takes over where it enables its output
    always_comb begin
        sixVal   = (sixPeriph.oe & sixPeriph.o) | (~sixPeriph.oe & st_reg.sixLatch);
        sixDrive = sixPeriph.oe | st_reg.sixDir;
        // open drain never drives high
        sixOe    = isoActive ? 8'h00 : (sixDrive & ~(SIX_OPEN_DRAIN & sixVal));
    end

    // registered pin outputs would add a cycle; these follow state directly
    assign sixPinOut.o  = sixVal;
    assign sixPinOut.oe = sixOe;
    // pull-up dropped while the pin is driven low, and on pins 0 and 1
    assign sixPinOut.pu = st_reg.sixPullup & dgp_pkg::SIX_PULLUP_MASK
                          & ~(sixOe & ~sixVal);
    assign sixCoreIn    = isoActive ? (sixPinIn & sixKeep) : sixPinIn;

    assign fPinOut = st_reg.fLatch;
    assign fPinOe  = isoActive ? 3'h0
                   : (st_reg.fDir & fUsable & ~(F_OPEN_DRAIN & st_reg.fLatch));
    assign fCoreIn = isoActive ? 3'h0 : fPinIn;

    assign busRdata = st_reg.rdata;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // two flops before pin levels reach the read path
        st_next.sixSync1 = sixPinIn;
        st_next.sixSync2 = st_reg.sixSync1;
        st_next.fSync1   = fPinIn;
        st_next.fSync2   = st_reg.fSync1;

        // enter isolation only if software asked for it
        if (stopOrWatch && st_reg.isolate) begin
            st_next.pmode = dgp_pkg::PM_ISOLATE;
        end else begin
            st_next.pmode = dgp_pkg::PM_RUN;
        end

        if (busReq.wr) begin
            case (busReq.addr)
                dgp_pkg::ADDR_SIX_LATCH:    st_next.sixLatch  = busReq.wdata;
                dgp_pkg::ADDR_SIX_DIR:      st_next.sixDir    = busReq.wdata;
                dgp_pkg::ADDR_SIX_PULLUP:   st_next.sixPullup = busReq.wdata;
                dgp_pkg::ADDR_F_LATCH:      st_next.fLatch    = busReq.wdata[2:0];
                dgp_pkg::ADDR_F_DIR:        st_next.fDir      = busReq.wdata[2:0];
                dgp_pkg::ADDR_STANDBY_CTRL: st_next.isolate   =
                                            busReq.wdata[dgp_pkg::STBY_ISOLATE_BIT];
                dgp_pkg::ADDR_WAKE_SELECT:  st_next.wakeSel   = busReq.wdata[3:0];
                default: begin
                end
            endcase
        end

        // read data stands for exactly one cycle after the strobe
        st_next.rdata = dgp_pkg::RST_BYTE;
        if (busReq.rd) begin
            case (busReq.addr)
                dgp_pkg::ADDR_SIX_LATCH:
                    st_next.rdata = mux_read(st_reg.sixLatch, st_reg.sixDir, sixPeriph.oe,
                                             st_reg.sixSync2, busReq.rmw);
                dgp_pkg::ADDR_SIX_DIR:      st_next.rdata = st_reg.sixDir;
                dgp_pkg::ADDR_SIX_PULLUP:   st_next.rdata = st_reg.sixPullup;
                dgp_pkg::ADDR_F_LATCH:
                    st_next.rdata = mux_read({5'h00, st_reg.fLatch}, {5'h00, st_reg.fDir},
                                             8'h00, {5'h00, st_reg.fSync2},
                                             busReq.rmw);
                dgp_pkg::ADDR_F_DIR:        st_next.rdata = {5'h00, st_reg.fDir};
                dgp_pkg::ADDR_STANDBY_CTRL: st_next.rdata = {7'h00, st_reg.isolate};
                dgp_pkg::ADDR_WAKE_SELECT:  st_next.rdata = {4'h0, st_reg.wakeSel};
                default:                    st_next.rdata = dgp_pkg::RST_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.sixLatch  <= dgp_pkg::RST_SIX_LATCH;
            st_reg.sixDir    <= dgp_pkg::RST_SIX_DIR;
            st_reg.sixPullup <= dgp_pkg::RST_SIX_PULLUP;
            st_reg.fLatch    <= dgp_pkg::RST_F_LATCH;
            st_reg.fDir      <= dgp_pkg::RST_F_DIR;
            st_reg.isolate   <= 1'b0;
            st_reg.wakeSel   <= 4'h0;
            st_reg.sixSync1  <= dgp_pkg::RST_BYTE;
            st_reg.sixSync2  <= dgp_pkg::RST_BYTE;
            st_reg.fSync1    <= 3'h0;
            st_reg.fSync2    <= 3'h0;
            st_reg.pmode     <= dgp_pkg::PM_RUN;
            st_reg.rdata     <= dgp_pkg::RST_BYTE;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

endmodule

//--- tb/dgp_port_props.sv
`timescale 1ns/1ps
// ----
// port behaviour checks
// ----
module dgp_port_props (
    input wire logic               sys_clk,
    input wire logic               rst_n,
    input wire logic               clkEn,
    input wire dgp_pkg::dgp_bus_t  busReq,
    input wire logic [7:0]         busRdata,
    input wire logic               stopOrWatch,
    input wire dgp_pkg::dgp_pins_t sixPeriph,
    input wire dgp_pkg::dgp_pins_t sixPinOut,
    input wire logic [2:0]         fPinOe,
    input wire logic [2:0]         fCoreIn
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] latchT;
    logic       isoT;
    logic       wrEn;
    assign wrEn = clkEn && busReq.wr;
    // shadow of latch and isolate bit, so checks need no internal probes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latchT <= dgp_pkg::RST_SIX_LATCH;
            isoT   <= 1'b0;
        end else if (wrEn && busReq.addr == dgp_pkg::ADDR_SIX_LATCH) begin
            latchT <= busReq.wdata;
        end else if (wrEn && busReq.addr == dgp_pkg::ADDR_STANDBY_CTRL) begin
            isoT   <= busReq.wdata[dgp_pkg::STBY_ISOLATE_BIT];
        end
    end
    property p_dir_oe;
        wrEn && !stopOrWatch && busReq.addr == dgp_pkg::ADDR_SIX_DIR
            |=> (sixPinOut.oe & ~sixPeriph.oe) == ($past(busReq.wdata) & ~sixPeriph.oe);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("direction not on enables");
    property p_latch_pin;
        wrEn && !stopOrWatch && busReq.addr == dgp_pkg::ADDR_SIX_LATCH
            |=> ((sixPinOut.o ^ $past(busReq.wdata)) & sixPinOut.oe & ~sixPeriph.oe) == 8'h00;
    endproperty
    a_latch_pin: assert property (p_latch_pin) else $error("latch not on pin");
    property p_reset;
        $rose(rst_n) |-> (sixPinOut.oe & ~sixPeriph.oe) == 8'h00 && fPinOe == 3'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("pins driven after reset");
    property p_periph;
        !stopOrWatch && !$past(stopOrWatch) |-> ((sixPinOut.o ^ sixPeriph.o) & sixPeriph.oe)
            == 8'h00 && (sixPinOut.oe & sixPeriph.oe) == sixPeriph.oe;
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral not on pin");
    property p_pull;
        (sixPinOut.pu & sixPinOut.oe & ~sixPinOut.o) == 8'h00 && sixPinOut.pu[1:0] == 2'h0;
    endproperty
    a_pull: assert property (p_pull) else $error("pull-up wrongly on");
    property p_iso;
        isoT && stopOrWatch && clkEn |=> sixPinOut.oe == 8'h00 && fPinOe == 3'h0
            && fCoreIn == 3'h0;
    endproperty
    a_iso: assert property (p_iso) else $error("pins not isolated");
    property p_hold;
        !isoT && stopOrWatch && clkEn && !busReq.wr ##1 $stable(sixPeriph) |-> $stable(sixPinOut);
    endproperty
    a_hold: assert property (p_hold) else $error("pins changed in standby");
    property p_rmw;
        clkEn && busReq.rd && busReq.rmw && busReq.addr == dgp_pkg::ADDR_SIX_LATCH
            |=> busRdata == latchT;
    endproperty
    a_rmw: assert property (p_rmw) else $error("rmw read not latch");
    c_iso: cover property (isoT && stopOrWatch);
    c_rmw: cover property (busReq.rd && busReq.rmw);
    c_periph: cover property (sixPeriph.oe != 8'h00);
endmodule

bind dgp_port dgp_port_props dgp_port_props_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .clkEn(clkEn), .busReq(busReq), .busRdata(busRdata), .stopOrWatch(stopOrWatch),
    .sixPeriph(sixPeriph), .sixPinOut(sixPinOut), .fPinOe(fPinOe), .fCoreIn(fCoreIn));

//--- tb/dgp_pad_model.sv
`timescale 1ns/1ps
// board pads: driven pins show the drive, released ones the pull-up or board level
module dgp_pad_model (
    input wire dgp_pkg::dgp_pins_t sixPinOut,
    input wire logic [7:0]         extSix,
    input wire logic [2:0]         fPinOut,
    input wire logic [2:0]         fPinOe,
    input wire logic [2:0]         extF,
    output logic [7:0]             sixPinIn,
    output logic [2:0]             fPinIn
);
    // board level is treated as weak, so a pull-up wins over it
    assign sixPinIn = (sixPinOut.oe & sixPinOut.o)
                    | (~sixPinOut.oe & (sixPinOut.pu | extSix));
    assign fPinIn   = (fPinOe & fPinOut) | (~fPinOe & extF);
endmodule

//--- tb/tb_dgp_port.sv
`timescale 1ns/1ps
module tb_dgp_port;
    logic               sys_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               stopOrWatch = 1'b0;
    logic               ce = 1'b1;
    dgp_pkg::dgp_bus_t  bq = '0;
    dgp_pkg::dgp_pins_t per = '0;
    dgp_pkg::dgp_pins_t six;
    logic [7:0]         rdat, sixIn, core, extSix = 8'h3C;
    logic [2:0]         fIn, fOut, fOe, fCore, extF = 3'h3;
    int                 fails = 0, cmp_count = 0;
    always #5 sys_clk = ~sys_clk;
    dgp_port dgp_port_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(ce), .busReq(bq),
        .busRdata(rdat), .stopOrWatch(stopOrWatch), .sixPeriph(per), .sixPinIn(sixIn),
        .sixPinOut(six), .sixCoreIn(core), .fPinIn(fIn), .fPinOut(fOut), .fPinOe(fOe),
        .fCoreIn(fCore));
    dgp_pad_model dgp_pad_model_inst (.sixPinOut(six), .extSix(extSix), .fPinOut(fOut),
        .fPinOe(fOe), .extF(extF), .sixPinIn(sixIn), .fPinIn(fIn));
    task chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bq <= '{a, d, 1'b1, 1'b0, 1'b0};
        @(posedge sys_clk);
        bq.wr <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a, input logic m, input logic [7:0] e);
        @(posedge sys_clk);
        bq <= '{a, 8'h00, 1'b0, 1'b1, m};
        @(posedge sys_clk);
        bq.rd <= 1'b0;
        #1 chk(rdat, e);
    endtask
    // pad levels need two synchroniser cycles before a read sees them
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        stopOrWatch <= stopOrWatch;
        #1;
    endtask
    task t_out;
        rd(dgp_pkg::ADDR_SIX_DIR, 1'b0, 8'h00);
        rd(dgp_pkg::ADDR_F_DIR, 1'b0, 8'h00);
        wr(dgp_pkg::ADDR_SIX_DIR, 8'hFF);
        wr(dgp_pkg::ADDR_SIX_LATCH, 8'hA5);
        chk(six.o, 8'hA5);
        rd(dgp_pkg::ADDR_SIX_LATCH, 1'b0, 8'hA5);
        wr(dgp_pkg::ADDR_SIX_DIR, 8'h0F);
        chk(six.oe, 8'h0F);
        cyc(3);
        rd(dgp_pkg::ADDR_SIX_LATCH, 1'b0, 8'h35);
        rd(dgp_pkg::ADDR_SIX_LATCH, 1'b1, 8'hA5);
        wr(4'hF, 8'hFF);
        rd(4'hF, 1'b0, 8'h00);
    endtask
    task t_periph;
        @(posedge sys_clk);
        per <= '{8'h80, 8'h80, 8'h00};
        cyc(3);
        chk(six.o & six.oe, 8'h85);
        rd(dgp_pkg::ADDR_SIX_LATCH, 1'b0, 8'hB5);
        rd(dgp_pkg::ADDR_SIX_LATCH, 1'b1, 8'hA5);
        @(posedge sys_clk);
        per <= '0;
    endtask
    task t_pull;
        wr(dgp_pkg::ADDR_SIX_PULLUP, 8'hFF);
        wr(dgp_pkg::ADDR_SIX_DIR, 8'h00);
        chk(six.pu, 8'hFC);
        cyc(3);
        rd(dgp_pkg::ADDR_SIX_LATCH, 1'b0, 8'hFC);
        wr(dgp_pkg::ADDR_SIX_DIR, 8'hFF);
        chk(six.pu, 8'hA4);
        wr(dgp_pkg::ADDR_SIX_PULLUP, 8'h00);
    endtask
    task t_portf;
        wr(dgp_pkg::ADDR_F_DIR, 8'h07);
        wr(dgp_pkg::ADDR_F_LATCH, 8'h05);
        chk({5'h00, fOut & fOe}, 8'h05);
        rd(dgp_pkg::ADDR_F_LATCH, 1'b0, 8'h05);
        wr(dgp_pkg::ADDR_F_DIR, 8'h00);
        cyc(3);
        rd(dgp_pkg::ADDR_F_LATCH, 1'b0, 8'h03);
        rd(dgp_pkg::ADDR_F_LATCH, 1'b1, 8'h05);
    endtask
    task t_iso;
        wr(dgp_pkg::ADDR_SIX_DIR, 8'hE0);
        wr(dgp_pkg::ADDR_STANDBY_CTRL, 8'h01);
        wr(dgp_pkg::ADDR_WAKE_SELECT, 8'h04);
        @(posedge sys_clk);
        stopOrWatch <= 1'b1;
        cyc(2);
        chk(six.oe | {5'h00, fOe}, 8'h00);
        chk(core, 8'h10);
        chk({5'h00, fCore}, 8'h00);
        stopOrWatch <= 1'b0;
        wr(dgp_pkg::ADDR_STANDBY_CTRL, 8'h00);
        @(posedge sys_clk);
        stopOrWatch <= 1'b1;
        cyc(3);
        chk(six.o & six.oe, 8'hA0);
        stopOrWatch <= 1'b0;
    endtask
    // a write while the clock enable is low must leave the latch alone
    task t_freeze;
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(dgp_pkg::ADDR_SIX_LATCH, 8'h00);
        chk(six.o, 8'hA5);
        ce <= 1'b1;
        rd(dgp_pkg::ADDR_SIX_LATCH, 1'b1, 8'hA5);
    endtask
    task end_sim;
        $display("compares %0d errors %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_out();
        t_periph();
        t_pull();
        t_portf();
        t_iso();
        t_freeze();
        end_sim();
    end
    // guard against a hung run
    initial begin
        #100000;
        fails++;
        end_sim();
    end
endmodule
